// file: shared/bitop_pkg.sv
// Constants shared by the bit set and bit clear sequencer
package bitop_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BITNUM_W = 3;
  // Opcode groups: upper five bits select the instruction, low three the bit
  localparam logic [4:0] OPC_CLEAR_GRP = 5'h14;
  localparam logic [4:0] OPC_SET_GRP = 5'h15;
  localparam int OPC_GRP_MSB = 7;
  localparam int OPC_GRP_LSB = 3;
  // Program address steps for operand and next opcode
  localparam logic [15:0] OPERAND_STEP = 16'h0001;
  localparam logic [15:0] NEXT_OP_STEP = 16'h0002;
  // Direct operand reaches the zero page
  localparam logic [7:0] DIR_PAGE = 8'h00;
  localparam int BUS_CYCLES = 4;
endpackage

// file: rtl/bit_set_clear_rmw_sequencer.sv
// Sequencer for single-bit set and clear as a four-cycle byte read-modify-write
// Operation
// - A bit set or clear reads the whole target byte, changes one bit and writes it back.
// - The instruction takes four bus cycles: operand fetch, marked read, write, next fetch.
// - An ordinary read of a port returns the pin levels.
// - The marked read of a port returns the output latch so other latch bits survive.
// - The latch is returned whatever the direction setting or pin state.
// - An ordinary read of an interrupt request flag returns its true state.
// - The marked read returns every interrupt request flag bit as one.
// - A flag clears on a written zero, and a written one leaves it unchanged.
module bit_set_clear_rmw_sequencer #(
  parameter int FLAG_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [15:0] op_addr,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] port_pins,
  input wire logic [7:0] port_dir,
  input wire logic port_sel,
  input wire logic flag_sel,
  input wire logic [FLAG_W-1:0] flag_events,
  output logic [15:0] addr,
  output logic [7:0] wr_data,
  output logic rd_n,
  output logic wr_n,
  output logic bit_update_marker,
  output logic busy,
  output logic done,
  output logic [7:0] port_latch,
  output logic [FLAG_W-1:0] irq_flags,
  output logic [7:0] read_back
);
  typedef enum logic [2:0] {S_IDLE, S_OPERAND, S_READ, S_WRITE, S_NEXT} seq_e;

  typedef struct packed {
    seq_e st;
    logic is_set;
    logic [2:0] bitnum;
    logic [15:0] pc;
    logic [15:0] addr;
    logic [7:0] wr_data;
    logic rd_n;
    logic wr_n;
    logic marker;
    logic busy;
    logic done;
    logic [7:0] latch;
    logic [FLAG_W-1:0] flags;
    logic [7:0] read_back;
    logic [7:0] pins_a;
    logic [7:0] pins_b;
    logic [FLAG_W-1:0] ev_a;
    logic [FLAG_W-1:0] ev_b;
  } state_s;

  state_s q_r;
  state_s q_nxt;

  function automatic logic [7:0] bit_apply(input logic [7:0] b, input logic [2:0] n,
                                           input logic s);
    logic [7:0] r;
    r = b;
    r[n] = s;
    return r;
  endfunction

  // Data presented on the read bus for the two modelled peripherals
  function automatic logic [7:0] read_mux(input state_s q, input logic psel, input logic fsel,
                                          input logic [7:0] mem);
    logic [7:0] r;
    r = mem;
    if (psel)
      r = q.marker ? q.latch : q.pins_b;
    else if (fsel)
      r = q.marker ? '1 : 8'(q.flags);
    return r;
  endfunction

  logic [7:0] rd_val;
  logic opc_ok;
  assign rd_val = read_mux(q_r, port_sel, flag_sel, rd_data);
  assign opc_ok = (opcode[bitop_pkg::OPC_GRP_MSB:bitop_pkg::OPC_GRP_LSB] ==
                   bitop_pkg::OPC_CLEAR_GRP) ||
                  (opcode[bitop_pkg::OPC_GRP_MSB:bitop_pkg::OPC_GRP_LSB] ==
                   bitop_pkg::OPC_SET_GRP);

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.pins_a = port_pins;
    q_nxt.pins_b = q_r.pins_a;
    q_nxt.ev_a = flag_events;
    q_nxt.ev_b = q_r.ev_a;
    q_nxt.done = 1'b0;
    q_nxt.rd_n = 1'b1;
    q_nxt.wr_n = 1'b1;
    q_nxt.marker = 1'b0;
    q_nxt.flags = q_r.flags | q_r.ev_b;
    case (q_r.st)
      S_IDLE:
      begin
        if (start && opc_ok)
        begin
          q_nxt.is_set = opcode[bitop_pkg::OPC_GRP_LSB];
          q_nxt.bitnum = opcode[bitop_pkg::BITNUM_W-1:0];
          q_nxt.pc = op_addr;
          q_nxt.addr = op_addr + bitop_pkg::OPERAND_STEP;
          q_nxt.rd_n = 1'b0;
          q_nxt.busy = 1'b1;
          q_nxt.st = S_OPERAND;
        end
      end
      S_OPERAND:
      begin
        // Operand fetch is an ordinary read, so it goes through the read mux
        q_nxt.addr = {bitop_pkg::DIR_PAGE, rd_val};
        q_nxt.rd_n = 1'b0;
        q_nxt.marker = 1'b1;
        q_nxt.st = S_READ;
      end
      S_READ:
      begin
        q_nxt.read_back = rd_val;
        q_nxt.wr_data = bit_apply(rd_val, q_r.bitnum, q_r.is_set);
        q_nxt.wr_n = 1'b0;
        q_nxt.st = S_WRITE;
      end
      S_WRITE:
      begin
        if (port_sel)
          q_nxt.latch = q_r.wr_data;
        if (flag_sel)
          q_nxt.flags = (q_r.flags & FLAG_W'(q_r.wr_data)) | q_r.ev_b;
        q_nxt.addr = q_r.pc + bitop_pkg::NEXT_OP_STEP;
        q_nxt.rd_n = 1'b0;
        q_nxt.st = S_NEXT;
      end
      S_NEXT:
      begin
        q_nxt.busy = 1'b0;
        q_nxt.done = 1'b1;
        q_nxt.st = S_IDLE;
      end
      default:
      begin
        q_nxt.st = S_IDLE;
        q_nxt.busy = 1'b0;
      end
    endcase
    if (!q_r.rd_n && (port_sel || flag_sel))
      q_nxt.read_back = rd_val;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= '0;
      q_r.st <= S_IDLE;
      q_r.rd_n <= 1'b1;
      q_r.wr_n <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  assign addr = q_r.addr;
  assign wr_data = q_r.wr_data;
  assign rd_n = q_r.rd_n;
  assign wr_n = q_r.wr_n;
  assign bit_update_marker = q_r.marker;
  assign busy = q_r.busy;
  assign done = q_r.done;
  assign port_latch = q_r.latch;
  assign irq_flags = q_r.flags;
  assign read_back = q_r.read_back;

  sequence s_marked_read;
    !rd_n && bit_update_marker;
  endsequence
  sequence s_write_phase;
    !wr_n && rd_n && !bit_update_marker;
  endsequence

  property p_four_cycles;
    @(posedge clk) disable iff (rst)
      (q_r.st == S_IDLE && start && opc_ok) |=> !rd_n ##1 s_marked_read ##1 s_write_phase
      ##1 (!rd_n && !bit_update_marker) ##1 done;
  endproperty
  a_four_cycles: assert property (p_four_cycles) else $error("sequence length wrong");

  property p_operand_addr;
    @(posedge clk) disable iff (rst)
      (q_r.st == S_IDLE && start && opc_ok) |=> addr == $past(op_addr) + bitop_pkg::OPERAND_STEP;
  endproperty
  a_operand_addr: assert property (p_operand_addr) else $error("operand address wrong");

  property p_same_addr;
    @(posedge clk) disable iff (rst)
      s_marked_read |=> $stable(addr);
  endproperty
  a_same_addr: assert property (p_same_addr) else $error("write address differs");

  property p_one_bit;
    @(posedge clk) disable iff (rst)
      s_marked_read |=> (((wr_data ^ $past(rd_val)) & ~(8'h01 << q_r.bitnum)) == 8'h00) &&
      (wr_data[q_r.bitnum] == q_r.is_set);
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("write data wrong");

  property p_latch_read;
    @(posedge clk) disable iff (rst)
      (s_marked_read and port_sel) |=> read_back == $past(port_latch);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("marked port read not latch");

  property p_flag_ones;
    @(posedge clk) disable iff (rst)
      (s_marked_read and flag_sel and !port_sel) |=> read_back == 8'hff;
  endproperty
  a_flag_ones: assert property (p_flag_ones) else $error("flags not read as one");

  property p_pin_read;
    @(posedge clk) disable iff (rst)
      (!rd_n && !bit_update_marker && port_sel) |=> read_back == $past(q_r.pins_b);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("plain port read not pins");

  property p_flag_true;
    @(posedge clk) disable iff (rst)
      (!rd_n && !bit_update_marker && flag_sel && !port_sel) |=>
      read_back == 8'($past(irq_flags));
  endproperty
  a_flag_true: assert property (p_flag_true) else $error("plain flag read wrong");

  property p_flag_keep;
    @(posedge clk) disable iff (rst)
      (!wr_n && flag_sel) |=> (irq_flags & ~$past(irq_flags) & ~$past(q_r.ev_b)) == '0;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag set by write");

  property p_flag_clear;
    @(posedge clk) disable iff (rst)
      (!wr_n && flag_sel) |=> (irq_flags & ~$past(FLAG_W'(wr_data)) & ~$past(q_r.ev_b)) == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by zero");
endmodule // bit_set_clear_rmw_sequencer

// file: verification/mem_model.sv
// Behavioural memory and address decode on the internal bus
module mem_model #(
  parameter logic [15:0] PORT_A = 16'h0030,
  parameter logic [15:0] FLAG_A = 16'h0031
) (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] rd_data,
  output logic port_sel,
  output logic flag_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  // Released bus shows the inverse, never a stale byte
  assign rd_data = rd_n ? ~mem[addr[7:0]] : mem[addr[7:0]];
  assign port_sel = addr == PORT_A;
  assign flag_sel = addr == FLAG_A;
  always @(posedge clk)
  begin
    if (!wr_n && !port_sel && !flag_sel)
    begin
      mem[addr[7:0]] <= wr_data;
    end
  end
endmodule // mem_model

// file: verification/testbench.sv
// Self-checking bench for the bit set and clear sequencer
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, start, port_sel, flag_sel, rd_n, wr_n, bit_update_marker, busy, done;
  logic [7:0] opcode, rd_data, port_pins, port_dir, flag_events, wr_data;
  logic [7:0] port_latch, irq_flags, read_back;
  logic [15:0] op_addr, addr;
  int n_errors = 0;
  int checks = 0;
  bit_set_clear_rmw_sequencer DUT (.clk(clk), .rst(rst), .start(start), .opcode(opcode),
    .op_addr(op_addr), .rd_data(rd_data), .port_pins(port_pins), .port_dir(port_dir),
    .port_sel(port_sel), .flag_sel(flag_sel), .flag_events(flag_events), .addr(addr),
    .wr_data(wr_data), .rd_n(rd_n), .wr_n(wr_n), .bit_update_marker(bit_update_marker),
    .busy(busy), .done(done), .port_latch(port_latch), .irq_flags(irq_flags),
    .read_back(read_back));
  mem_model mem_i (.clk(clk), .addr(addr), .wr_data(wr_data), .rd_n(rd_n), .wr_n(wr_n),
    .rd_data(rd_data), .port_sel(port_sel), .flag_sel(flag_sel));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One instruction from a falling edge, checked phase by phase
  task automatic run(input logic [7:0] opc, input logic [15:0] n, input logic [15:0] tgt,
    input logic [7:0] wd, input logic [7:0] rb);
    start = 1'b1;
    opcode = opc;
    op_addr = n;
    @(negedge clk);
    start = 1'b0;
    chk({addr, rd_n, wr_n, bit_update_marker, busy}, {n + 16'h0001, 4'b0101});
    @(negedge clk);
    chk({addr, rd_n, wr_n, bit_update_marker}, {tgt, 3'b011});
    @(negedge clk);
    chk({addr, rd_n, wr_n, bit_update_marker, wr_data}, {tgt, 3'b100, wd});
    chk(read_back, rb);
    @(negedge clk);
    chk({addr, rd_n, wr_n, bit_update_marker}, {n + 16'h0002, 3'b010});
    @(negedge clk);
    chk({done, busy}, 2'b10);
  endtask
  task automatic sc_ram;
    mem_i.mem[8'h81] = 8'h10;
    mem_i.mem[8'h10] = 8'hf0;
    run(8'hab, 16'h0080, 16'h0010, 8'hf8, 8'hf0);
    run(8'ha4, 16'h0080, 16'h0010, 8'he8, 8'hf8);
    chk(mem_i.mem[8'h10], 8'he8);
  endtask
  task automatic sc_port;
    port_pins = 8'h0f;
    port_dir = 8'hff;
    mem_i.mem[8'h83] = 8'h30;
    run(8'ha8, 16'h0082, 16'h0030, 8'h01, 8'h00);
    port_dir = 8'h00;
    run(8'haf, 16'h0082, 16'h0030, 8'h81, 8'h01);
    chk(port_latch, 8'h81);
  endtask
  task automatic sc_pins;
    port_pins = 8'h12;
    repeat (3) @(negedge clk);
    mem_i.mem[8'h12] = 8'h00;
    run(8'ha8, 16'h002f, 16'h0012, 8'h01, 8'h00);
    // Next fetch lands on the port: read_back must show pins, not latch
    mem_i.mem[8'h2f] = 8'h12;
    run(8'ha8, 16'h002e, 16'h0012, 8'h01, 8'h01);
    chk(read_back, 8'h12);
  endtask
  task automatic sc_flag;
    flag_events = 8'h24;
    repeat (3) @(negedge clk);
    flag_events = 8'h00;
    repeat (3) @(negedge clk);
    mem_i.mem[8'h24] = 8'h00;
    run(8'ha8, 16'h0030, 16'h0024, 8'h01, 8'h00);
    mem_i.mem[8'h33] = 8'h31;
    run(8'ha5, 16'h0032, 16'h0031, 8'hdf, 8'hff);
    chk(irq_flags, 8'h04);
  endtask
  // Reset in mid-instruction, then a clean instruction
  task automatic sc_reset;
    mem_i.mem[8'h41] = 8'h50;
    mem_i.mem[8'h50] = 8'h00;
    start = 1'b1;
    opcode = 8'ha9;
    op_addr = 16'h0040;
    repeat (2) @(negedge clk);
    start = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    chk({busy, done, rd_n, wr_n, bit_update_marker, port_latch, irq_flags},
      {5'b00110, 8'h00, 8'h00});
    rst = 1'b0;
    @(negedge clk);
    run(8'ha9, 16'h0040, 16'h0050, 8'h02, 8'h00);
  endtask
  task automatic sc_refuse;
    start = 1'b1;
    opcode = 8'h12;
    repeat (3) @(negedge clk);
    chk({busy, rd_n}, 2'b01);
    start = 1'b0;
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    opcode = 8'h00;
    op_addr = 16'h0000;
    port_pins = 8'h00;
    port_dir = 8'h00;
    flag_events = 8'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    sc_ram();
    sc_port();
    sc_pins();
    sc_flag();
    sc_reset();
    sc_refuse();
    end_of_test();
  end
endmodule // testbench
